// ===== sim/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
   // open-drain lines, high = pull low
   input  wire logic scl_w,
   input  wire logic sda_w,
   output logic      scl_oe,
   output logic      sda_oe
);
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end

   // also serves as repeated start from a low clock
   task automatic start_cond();
      sda_oe = 1'b0;
      #40;
      scl_oe = 1'b0;
      wait (scl_w === 1'b1);
      #40;
      sda_oe = 1'b1;
      #40;
      scl_oe = 1'b1;
      #40;
   endtask

   task automatic put_bit(input logic b);
      sda_oe = ~b;
      #40;
      scl_oe = 1'b0;
      // a held clock line stalls us here
      wait (scl_w === 1'b1);
      #80;
      scl_oe = 1'b1;
      #40;
   endtask

   task automatic get_bit(output logic b);
      sda_oe = 1'b0;
      #40;
      scl_oe = 1'b0;
      wait (scl_w === 1'b1);
      #40;
      b = sda_w;
      #40;
      scl_oe = 1'b1;
      #40;
   endtask

   task automatic put_byte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i]);
      end
   endtask

   task automatic get_byte(output logic [7:0] v, input logic ack);
      for (int i = 7; i >= 0; i--) begin
         get_bit(v[i]);
      end
      put_bit(~ack);
   endtask

   task automatic stop_cond();
      sda_oe = 1'b1;
      #40;
      scl_oe = 1'b0;
      wait (scl_w === 1'b1);
      #40;
      sda_oe = 1'b0;
      #80;
   endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench
   import two_wire_pkg::*;
();
   logic       clk, arst_n, ctrl_wr, wr_ack_en, wr_start, wr_stop, wr_flag;
   logic [7:0] own_addr, tx_data, status, rd;
   logic       scl_oe, sda_oe, flag, ack_enable, start_request, stop_request;
   logic       master_active, rx_handoff, m_scl_oe, m_sda_oe, b;
   wire logic  scl_w;
   wire logic  sda_w;
   int         err_total, cmp_count, cycles, stops, gc_seen, n;

   // pull-ups: a released line reads high
   assign scl_w = ~(scl_oe | m_scl_oe);
   assign sda_w = ~(sda_oe | m_sda_oe);

   two_wire_slave_tx u_dut (
      .CLK(clk), .ARST_N(arst_n), .SCL_I(scl_w), .SCL_O(), .SCL_OE(scl_oe),
      .SDA_I(sda_w), .SDA_O(), .SDA_OE(sda_oe), .CTRL_WR(ctrl_wr),
      .WR_ACK_EN(wr_ack_en), .WR_START(wr_start), .WR_STOP(wr_stop),
      .WR_FLAG(wr_flag), .OWN_ADDR(own_addr), .TX_DATA(tx_data), .STATUS(status),
      .TRANSFER_DONE(flag), .ACK_ENABLE(ack_enable), .START_REQUEST(start_request),
      .STOP_REQUEST(stop_request), .MASTER_ACTIVE(master_active),
      .RX_HANDOFF(rx_handoff));

   bus_master_model m (.scl_w(scl_w), .sda_w(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ----------------------------------------------------------
   // monitors and timeout
   // ----------------------------------------------------------
   always @(posedge sda_w) if (scl_w === 1'b1) stops++;
   always @(posedge clk) if (rx_handoff === 1'b1) gc_seen++;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         end_sim();
      end
   end

   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // every software write answers with the flag written one
   task automatic ctl(input logic ack, input logic st, input logic sp, input logic [7:0] d);
      @(negedge clk);
      ctrl_wr = 1'b1;
      wr_ack_en = ack;
      wr_start = st;
      wr_stop = sp;
      wr_flag = 1'b1;
      tx_data = d;
      @(negedge clk);
      ctrl_wr = 1'b0;
   endtask

   task automatic wait_flag(input logic [7:0] code);
      int k = 0;
      while (flag !== 1'b1 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      check(status, code);
   endtask

   task automatic address(input logic [7:0] a);
      m.start_cond();
      m.put_byte(a);
      m.get_bit(b);
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      {ctrl_wr, wr_ack_en, wr_start, wr_stop, wr_flag} = 5'h00;
      own_addr = 8'hA4;
      tx_data = 8'h00;
      arst_n = 1'b0;
      repeat (20) @(negedge clk);
      arst_n = 1'b1;
      check(status, ST_NONE);
      check(flag, 8'h00);
      check(ack_enable, RST_ACK_EN);
      ctl(1'b1, 1'b0, 1'b0, 8'h00);
      check(ack_enable, 8'h01);
      address(8'hA5);
      check(b, 8'h00);
      wait_flag(ST_SLA_R_ACK);
      repeat (20) @(negedge clk);
      // the model holds the clock too, so look at our own pull-down
      check(scl_oe, 8'h01);
      ctl(1'b1, 1'b0, 1'b0, 8'hA5);
      check(status, ST_NONE);
      m.get_byte(rd, 1'b1);
      check(rd, 8'hA5);
      wait_flag(ST_DATA_ACK);
      ctl(1'b0, 1'b0, 1'b0, 8'h3C);
      m.get_byte(rd, 1'b1);
      check(rd, 8'h3C);
      wait_flag(ST_LAST_ACK);
      ctl(1'b0, 1'b0, 1'b0, 8'h00);
      m.get_byte(rd, 1'b0);
      check(rd, 8'hFF);
      m.stop_cond();
      address(8'hA5);
      check(b, 8'h01);
      repeat (50) @(negedge clk);
      check(flag, 8'h00);
      m.stop_cond();
      for (int g = 0; g < 2; g++) begin
         @(negedge clk);
         own_addr = {7'h52, g[0]};
         n = gc_seen;
         ctl(1'b1, 1'b0, 1'b0, 8'h00);
         address(8'h00);
         m.stop_cond();
         check(gc_seen != n, g[0]);
      end
      @(negedge clk);
      own_addr = 8'hA4;
      address(8'hA5);
      wait_flag(ST_SLA_R_ACK);
      ctl(1'b1, 1'b0, 1'b0, 8'h81);
      m.get_byte(rd, 1'b0);
      check(rd, 8'h81);
      wait_flag(ST_DATA_NACK);
      // start asked while the remote master still holds the bus
      ctl(1'b1, 1'b1, 1'b0, 8'h5A);
      repeat (100) @(negedge clk);
      check(master_active, 8'h00);
      check(start_request, 8'h01);
      m.stop_cond();
      n = stops;
      wait_flag(ST_MADDR_NACK);
      check(start_request, 8'h00);
      ctl(1'b1, 1'b1, 1'b0, 8'h5B);
      wait_flag(ST_MADDR_NACK);
      check(master_active, 8'h01);
      check(stops - n, 8'h00);
      ctl(1'b1, 1'b0, 1'b0, 8'h00);
      for (int k = 0; k < 500 && master_active !== 1'b0; k++) @(negedge clk);
      check(master_active, 8'h00);
      check(stops - n, 8'h01);
      address(8'hA5);
      wait_flag(ST_SLA_R_ACK);
      ctl(1'b1, 1'b0, 1'b0, 8'hFF);
      m.get_bit(b);
      m.get_bit(b);
      // start in mid data byte
      m.start_cond();
      wait_flag(ST_BUS_ERR);
      check({sda_oe, scl_oe}, 8'h00);
      n = stops;
      ctl(1'b1, 1'b0, 1'b1, 8'h00);
      repeat (3) @(negedge clk);
      check(stop_request, 8'h00);
      check(ack_enable, 8'h01);
      check(status, ST_NONE);
      check(stops - n, 8'h00);
      m.stop_cond();
      end_sim();
   end
endmodule

// ===== src/two_wire_pkg.sv
package two_wire_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned T_CLK_PS  = 4000;
   localparam int unsigned T_HALF_NS = 80;
   // least time, so round up
   localparam int unsigned HALF_CYC  = (T_HALF_NS * 1000 + T_CLK_PS - 1) / T_CLK_PS;

   // ------------------------------------------------------------
   // status codes, low three bits are masked to zero
   // ------------------------------------------------------------
   localparam logic [7:0] STAT_MASK     = 8'hF8;
   localparam logic [7:0] ST_SLA_R_ACK  = 8'hA8;
   localparam logic [7:0] ST_ARB_SLA_R  = 8'hB0;
   localparam logic [7:0] ST_DATA_ACK   = 8'hB8;
   localparam logic [7:0] ST_DATA_NACK  = 8'hC0;
   localparam logic [7:0] ST_LAST_ACK   = 8'hC8;
   localparam logic [7:0] ST_NONE       = 8'hF8;
   localparam logic [7:0] ST_BUS_ERR    = 8'h00;
   localparam logic [7:0] ST_ARB_LOST   = 8'hE0;
   localparam logic [7:0] ST_MADDR_ACK  = 8'hE8;
   localparam logic [7:0] ST_MADDR_NACK = 8'hF0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic       RST_ACK_EN = 1'b0;
   localparam logic [7:0] RST_CODE   = 8'hF8;

   typedef enum logic [9:0] {
      S_IDLE = 10'b00_0000_0001,
      S_ADDR = 10'b00_0000_0010,
      S_AACK = 10'b00_0000_0100,
      S_TX   = 10'b00_0000_1000,
      S_RACK = 10'b00_0001_0000,
      S_WAIT = 10'b00_0010_0000,
      S_MSTA = 10'b00_0100_0000,
      S_MACK = 10'b00_1000_0000,
      S_RSTA = 10'b01_0000_0000,
      S_MSTP = 10'b10_0000_0000
   } state_t;

endpackage

// ===== src/two_wire_slave_tx.sv
`timescale 1ns/1ps
module two_wire_slave_tx
   import two_wire_pkg::*;
#(
   parameter int unsigned HALF_CYCLES = HALF_CYC
) (
   // clock and reset
   input  wire logic       CLK,
   input  wire logic       ARST_N,
   // bus pins
   input  wire logic       SCL_I,
   output logic            SCL_O,
   output logic            SCL_OE,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE,
   // software control write
   input  wire logic       CTRL_WR,
   input  wire logic       WR_ACK_EN,
   input  wire logic       WR_START,
   input  wire logic       WR_STOP,
   input  wire logic       WR_FLAG,
   input  wire logic [7:0] OWN_ADDR,
   input  wire logic [7:0] TX_DATA,
   // software status
   output logic [7:0]      STATUS,
   output logic            TRANSFER_DONE,
   output logic            ACK_ENABLE,
   output logic            START_REQUEST,
   output logic            STOP_REQUEST,
   output logic            MASTER_ACTIVE,
   output logic            RX_HANDOFF
);

   typedef struct packed {
      state_t     st;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic       scl_f;
      logic       sda_f;
      logic       busy;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic       out_bit;
      logic       last;
      logic       master;
      logic       lost;
      logic       ack_seen;
      logic       flag;
      logic [7:0] code;
      logic [7:0] status;
      logic       ack_en;
      logic       start;
      logic       stop;
      logic       scl_oe;
      logic       sda_oe;
      logic       rxh;
      logic       lo;
      logic [15:0] div;
   } regs_t;

   localparam regs_t RST = '{st: S_IDLE, scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1,
                             sda_f: 1'b1, code: RST_CODE, status: ST_NONE,
                             ack_en: RST_ACK_EN, default: '0};

   regs_t q;
   regs_t d;
   logic  rise;
   logic  fall;
   logic  sc;
   logic  sp;
   logic  tick;
   logic  clr;
   logic  frame;
   logic  mclk;
   logic  set_ev;
   logic  own_hit;
   logic  gc_hit;
   logic [7:0] code_n;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      d      = q;
      set_ev = 1'b0;
      code_n = q.code;
      d.rxh  = 1'b0;
      // the first stage feeds only the second
      d.scl_s = {q.scl_s[1:0], SCL_I};
      d.sda_s = {q.sda_s[1:0], SDA_I};
      if (q.scl_s[1] == q.scl_s[2]) begin
         d.scl_f = q.scl_s[2];
      end
      if (q.sda_s[1] == q.sda_s[2]) begin
         d.sda_f = q.sda_s[2];
      end
      rise = d.scl_f & ~q.scl_f;
      fall = ~d.scl_f & q.scl_f;
      sc   = q.scl_f & d.scl_f & q.sda_f & ~d.sda_f;
      sp   = q.scl_f & d.scl_f & ~q.sda_f & d.sda_f;
      tick = (q.div == 16'(HALF_CYCLES - 1));
      d.div = tick ? 16'h0000 : q.div + 16'h0001;
      // a stretched low must not be cut short by our own divider
      mclk = q.master & tick & (q.scl_oe ? ~q.scl_f : q.scl_f);
      if (sc) begin
         d.busy = 1'b1;
      end else if (sp) begin
         d.busy = 1'b0;
      end
      if (CTRL_WR) begin
         d.ack_en = WR_ACK_EN;
         d.start  = WR_START;
         d.stop   = WR_STOP;
      end
      clr = CTRL_WR & WR_FLAG & q.flag;
      own_hit = (q.sh[7:1] == OWN_ADDR[7:1]) & q.ack_en;
      gc_hit  = (q.sh[7:1] == 7'h00) & OWN_ADDR[0] & q.ack_en;
      frame = ((q.st == S_ADDR) & (q.cnt != 4'h0)) | (q.st == S_AACK) | (q.st == S_TX)
            | (q.st == S_RACK);
      unique case (q.st)
         S_IDLE: begin
            d.sda_oe = 1'b0;
            if (sc) begin
               d.st   = S_ADDR;
               d.cnt  = 4'h0;
               d.lost = 1'b0;
            end else if (q.start & ~q.busy & ~q.flag) begin
               d.st     = S_MSTA;
               d.sda_oe = 1'b1;
               d.div    = 16'h0000;
            end
         end
         S_MSTA: begin
            if (tick) begin
               d.scl_oe  = 1'b1;
               d.master  = 1'b1;
               d.start   = 1'b0;
               d.sh      = TX_DATA;
               d.out_bit = TX_DATA[7];
               d.sda_oe  = ~TX_DATA[7];
               d.cnt     = 4'h0;
               d.st      = S_ADDR;
            end
         end
         S_RSTA: begin
            d.sda_oe = 1'b0;
            if (tick & q.scl_oe) begin
               d.scl_oe = 1'b0;
            end else if (tick & q.scl_f & q.sda_f) begin
               d.sda_oe = 1'b1;
               d.div    = 16'h0000;
               d.st     = S_MSTA;
            end
         end
         S_ADDR: begin
            d.sda_oe = q.master & ~q.out_bit;
            if (mclk) begin
               d.scl_oe = ~q.scl_oe;
            end
            if (rise) begin
               d.sh  = {q.sh[6:0], d.sda_f};
               d.cnt = q.cnt + 4'h1;
               // equal bits never lose, only a driven one read back as zero
               if (q.master & q.out_bit & ~d.sda_f) begin
                  d.master = 1'b0;
                  d.lost   = 1'b1;
                  d.scl_oe = 1'b0;
                  d.sda_oe = 1'b0;
               end
            end else if (fall & (q.cnt == 4'h8)) begin
               if (q.master) begin
                  d.sda_oe = 1'b0;
                  d.st     = S_MACK;
               end else if (own_hit & q.sh[0]) begin
                  d.sda_oe = 1'b1;
                  d.st     = S_AACK;
               end else if (q.lost) begin
                  d.rxh    = own_hit | gc_hit;
                  set_ev   = 1'b1;
                  code_n   = ST_ARB_LOST;
                  d.scl_oe = 1'b1;
                  d.st     = S_WAIT;
               end else begin
                  d.rxh = own_hit | gc_hit;
                  d.st  = S_IDLE;
               end
            end else if (fall) begin
               d.out_bit = q.sh[7];
               d.sda_oe  = q.master & ~q.sh[7];
            end
         end
         S_AACK: begin
            if (fall) begin
               d.sda_oe = 1'b0;
               d.scl_oe = 1'b1;
               set_ev   = 1'b1;
               code_n   = q.lost ? ST_ARB_SLA_R : ST_SLA_R_ACK;
               d.st     = S_WAIT;
            end
         end
         S_TX: begin
            d.sda_oe = ~q.out_bit;
            if (rise) begin
               d.sh  = {q.sh[6:0], d.sda_f};
               d.cnt = q.cnt + 4'h1;
            end else if (fall & (q.cnt == 4'h8)) begin
               d.sda_oe = 1'b0;
               d.st     = S_RACK;
            end else if (fall) begin
               d.out_bit = q.sh[7];
               d.sda_oe  = ~q.sh[7];
            end
         end
         S_RACK, S_MACK: begin
            if (mclk) begin
               d.scl_oe = ~q.scl_oe;
            end
            if (rise) begin
               d.ack_seen = ~d.sda_f;
            end else if (fall) begin
               d.scl_oe = 1'b1;
               set_ev   = 1'b1;
               d.st     = S_WAIT;
               if (q.st == S_MACK) begin
                  code_n = q.ack_seen ? ST_MADDR_ACK : ST_MADDR_NACK;
               end else if (~q.ack_seen) begin
                  code_n = ST_DATA_NACK;
               end else begin
                  code_n = q.last ? ST_LAST_ACK : ST_DATA_ACK;
               end
            end
         end
         S_WAIT: begin
            d.sda_oe = 1'b0;
            if (clr) begin
               unique case (q.code)
                  ST_SLA_R_ACK, ST_ARB_SLA_R, ST_DATA_ACK: begin
                     d.sh      = TX_DATA;
                     d.out_bit = TX_DATA[7];
                     d.sda_oe  = ~TX_DATA[7];
                     d.last    = ~d.ack_en;
                     d.cnt     = 4'h0;
                     d.scl_oe  = 1'b0;
                     d.st      = S_TX;
                  end
                  ST_BUS_ERR: begin
                     d.stop   = 1'b0;
                     d.scl_oe = 1'b0;
                     d.master = 1'b0;
                     d.st     = S_IDLE;
                  end
                  ST_MADDR_ACK, ST_MADDR_NACK: begin
                     // keeping the bus between pointer write and read
                     d.st = d.start ? S_RSTA : S_MSTP;
                  end
                  default: begin
                     // start request stays queued for the idle state
                     d.scl_oe = 1'b0;
                     d.st     = S_IDLE;
                  end
               endcase
            end
         end
         S_MSTP: begin
            d.sda_oe = 1'b1;
            if (tick & q.scl_oe) begin
               d.scl_oe = 1'b0;
            end else if (tick & q.scl_f) begin
               d.sda_oe = 1'b0;
               d.stop   = 1'b0;
               d.master = 1'b0;
               d.st     = S_IDLE;
            end
         end
      endcase
      // a stray start or stop inside a slave byte or ack drops everything
      if ((sc | sp) & frame & ~q.master) begin
         set_ev   = 1'b1;
         code_n   = ST_BUS_ERR;
         d.sda_oe = 1'b0;
         d.scl_oe = 1'b0;
         d.st     = S_WAIT;
      end
      if (set_ev) begin
         d.code = code_n;
      end
      d.flag   = set_ev | (q.flag & ~clr);
      d.status = d.flag ? (d.code & STAT_MASK) : ST_NONE;
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   assign SCL_O         = q.lo;
   assign SCL_OE        = q.scl_oe;
   assign SDA_O         = q.lo;
   assign SDA_OE        = q.sda_oe;
   assign STATUS        = q.status;
   assign TRANSFER_DONE = q.flag;
   assign ACK_ENABLE    = q.ack_en;
   assign START_REQUEST = q.start;
   assign STOP_REQUEST  = q.stop;
   assign MASTER_ACTIVE = q.master;
   assign RX_HANDOFF    = q.rxh;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_err_pending;
      q.flag && q.code == ST_BUS_ERR;
   endsequence
   sequence s_recover_wr;
      CTRL_WR && WR_FLAG && WR_STOP;
   endsequence

   chk_stretch_held: assert property (q.flag && q.code != ST_BUS_ERR |-> q.scl_oe)
      else $error("clock not held while flag set");
   chk_idle_status: assert property (!q.flag |-> q.status == ST_NONE)
      else $error("status not F8 with flag clear");
   chk_addr_read_a8: assert property ($rose(q.flag) && q.status == ST_SLA_R_ACK
      |-> $past(q.st) == S_AACK && !q.lost)
      else $error("A8 without own read address");
   chk_arb_b0: assert property ($rose(q.flag) && q.status == ST_ARB_SLA_R |-> q.lost)
      else $error("B0 without lost arbitration");
   chk_last_c8: assert property ($rose(q.flag) && q.status == ST_LAST_ACK |-> q.last)
      else $error("C8 on a byte not sent as last");
   chk_buserr_flag: assert property ((sc || sp) && frame && !q.master
      |=> q.flag && q.status == ST_BUS_ERR && !q.scl_oe && !q.sda_oe)
      else $error("bus error not reported");
   chk_err_recover: assert property (s_err_pending ##0 s_recover_wr
      |=> q.st == S_IDLE && !q.stop && !q.scl_oe ##1 !q.sda_oe)
      else $error("bus error recovery wrong");
   chk_arb_loss: assert property (q.master && q.out_bit && rise && !d.sda_f && q.st == S_ADDR
      |=> !q.master && q.lost && !q.scl_oe)
      else $error("arbitration loss missed");
   chk_start_queue: assert property (q.st == S_IDLE && q.start && !q.busy && !q.flag && !sc
      |=> q.st == S_MSTA && q.sda_oe)
      else $error("queued start not issued");
   chk_tx_load: assert property (q.flag && q.code == ST_DATA_ACK && clr
      |=> q.st == S_TX && q.sh == $past(TX_DATA) && q.last == !$past(d.ack_en))
      else $error("next byte not loaded");
   chk_ignore_idle: assert property (q.st == S_IDLE |-> !q.sda_oe)
      else $error("idle slave drives data");

endmodule
